// File: asr_dev.sv
// converter end: serial command decoder, register map, channel sequencer
// assumes link pins are asynchronous to core_clk_in and much slower than it
`timescale 1ns/100ps
`default_nettype none
module asr_dev
    import asr_pkg::*;
#(
    parameter logic [15:0] ID_CODE    = 16'hA5C0, // arbitrary value
    parameter logic [23:0] GAIN_RESET = 24'h555550 // arbitrary factory value
)(
    input  wire logic        core_clk_in,
    input  wire logic        nrst_in,
    asr_if.dev               link,
    input  wire logic        conv_tick_in,
    output logic [3:0]       active_channel_out,
    output logic [2:0]       active_setup_out,
    output logic             bipolar_out,
    output logic [1:0]       ref_select_out
);
    typedef enum logic [1:0] {ST_CMD = 2'b01, ST_DATA = 2'b10} asr_st_e;

    // ****************************************
    // pin synchronisers and edges
    // ****************************************
    logic [2:0] sclk_s_q;
    logic [1:0] cs_s_q;
    logic [1:0] din_s_q;
    logic       rise;
    logic       fall;
    logic       cs_n;
    logic       din;

    always_ff @(posedge core_clk_in)
    begin
        if (!nrst_in)
        begin
            sclk_s_q <= 3'h7;
            cs_s_q   <= 2'h3;
            din_s_q  <= 2'h3;
        end
        else
        begin
            sclk_s_q <= {sclk_s_q[1:0], link.sclk};
            cs_s_q   <= {cs_s_q[0], link.cs_n};
            din_s_q  <= {din_s_q[0], link.din};
        end
    end

    assign cs_n = cs_s_q[1];
    assign din  = din_s_q[1];
    assign rise = sclk_s_q[1] & ~sclk_s_q[2] & ~cs_n;
    assign fall = ~sclk_s_q[1] & sclk_s_q[2] & ~cs_n;

    // ****************************************
    // resynchronisation by a run of ones
    // ****************************************
    logic [6:0] ones_q;
    logic       wipe;

    assign wipe = rise & din & (ones_q == RESYNC_ONES - 7'h01);

    always_ff @(posedge core_clk_in)
    begin
        if (!nrst_in || wipe)
            ones_q <= 7'h00;
        else if (rise)
            ones_q <= din ? ones_q + 7'h01 : 7'h00;
    end

    // ****************************************
    // command and data shifting
    // ****************************************
    asr_st_e     st_q;
    logic [4:0]  cnt_q;
    logic [23:0] sh_q;
    logic [23:0] out_q;
    logic [5:0]  addr_q;
    logic        rd_q;
    logic [4:0]  len;
    logic [7:0]  cmd;
    logic        wr_now;
    logic [23:0] rd_val;

    assign cmd    = {sh_q[6:0], din};
    assign len    = asr_len(addr_q);
    assign wr_now = rise & (st_q == ST_DATA) & ~rd_q & (cnt_q == len - 5'h01);

    always_ff @(posedge core_clk_in)
    begin
        // cs high clears state here; sclk idle between bytes in 3-wire use keeps it
        if (!nrst_in || wipe || cs_n)
        begin
            st_q   <= ST_CMD;
            cnt_q  <= 5'h00;
            sh_q   <= 24'h000000;
            addr_q <= 6'h00;
            rd_q   <= 1'b0;
        end
        else if (rise)
        begin
            sh_q <= {sh_q[22:0], din};
            unique case (st_q)
                ST_CMD:
                begin
                    cnt_q <= cnt_q + 5'h01;
                    if (cnt_q == 5'h07)
                    begin
                        cnt_q <= 5'h00;
                        // a command with wen high is dropped unanswered
                        if (!cmd[CMD_WEN_BIT])
                        begin
                            st_q   <= ST_DATA;
                            addr_q <= cmd[5:0];
                            rd_q   <= cmd[CMD_READ_BIT];
                        end
                    end
                end
                ST_DATA:
                begin
                    cnt_q <= cnt_q + 5'h01;
                    if (cnt_q == len - 5'h01)
                    begin
                        st_q  <= ST_CMD;
                        cnt_q <= 5'h00;
                    end
                end
            endcase
        end
    end

    // read shadow: loaded on the command's last rise, shifted out on falls
    always_ff @(posedge core_clk_in)
    begin
        if (!nrst_in || wipe || cs_n)
            out_q <= 24'h000000;
        else if (rise && st_q == ST_CMD && cnt_q == 5'h07 && !cmd[CMD_WEN_BIT])
            out_q <= rd_val << (6'h18 - {1'b0, asr_len(cmd[5:0])});
        else if (fall && st_q == ST_DATA && rd_q)
            out_q <= {out_q[22:0], 1'b0};
    end

    always_ff @(posedge core_clk_in)
    begin
        if (!nrst_in)
        begin
            link.dout    <= 1'b1;
            link.dout_oe <= 1'b0;
        end
        else
        begin
            link.dout_oe <= ~cs_n;
            if (fall && st_q == ST_DATA && rd_q)
                link.dout <= out_q[23];
            else if (cs_n)
                link.dout <= 1'b1;
        end
    end

    // ****************************************
    // register map
    // ****************************************
    logic [15:0] adc_mode_q;
    logic [15:0] if_mode_q;
    logic [15:0] chan_q  [16];
    logic [15:0] setup_q [8];
    logic [15:0] filt_q  [8];
    logic [23:0] offs_q  [8];
    logic [23:0] gain_q  [8];
    logic [23:0] wdata;

    assign wdata = {sh_q[22:0], din};

    always_comb
    begin
        // decoded from the incoming command: addr_q only loads on that same edge
        rd_val = 24'h000000;
        if (cmd[5:0] == A_ADC_MODE)
            rd_val = {8'h00, adc_mode_q};
        else if (cmd[5:0] == A_IF_MODE)
            rd_val = {8'h00, if_mode_q};
        else if (cmd[5:0] == A_IDENTITY)
            rd_val = {8'h00, ID_CODE};
        else if (cmd[5:4] == A_CHANNEL0[5:4])
            rd_val = {8'h00, chan_q[cmd[3:0]]};
        else if (cmd[5:3] == A_SETUP0[5:3])
            rd_val = {8'h00, setup_q[cmd[2:0]]};
        else if (cmd[5:3] == A_FILTER0[5:3])
            rd_val = {8'h00, filt_q[cmd[2:0]]};
        else if (cmd[5:3] == A_OFFSET_0[5:3])
            rd_val = offs_q[cmd[2:0]];
        else if (cmd[5:3] == A_GAIN_0[5:3])
            rd_val = gain_q[cmd[2:0]];
    end

    always_ff @(posedge core_clk_in)
    begin
        if (!nrst_in || wipe)
        begin
            adc_mode_q <= RST_ADC_MODE;
            if_mode_q  <= RST_IF_MODE;
            for (int i = 0; i < 16; i++)
                chan_q[i] <= (i == 0) ? RST_CHANNEL0 : RST_CHANNELN;
            for (int i = 0; i < 8; i++)
            begin
                setup_q[i] <= RST_SETUP;
                filt_q[i]  <= RST_FILTER;
                offs_q[i]  <= RST_OFFSET;
                gain_q[i]  <= GAIN_RESET;
            end
        end
        else if (wr_now)
        begin
            if (addr_q == A_ADC_MODE)
                adc_mode_q <= wdata[15:0];
            else if (addr_q == A_IF_MODE)
                if_mode_q <= wdata[15:0];
            else if (addr_q[5:4] == A_CHANNEL0[5:4])
                chan_q[addr_q[3:0]] <= wdata[15:0] & MASK_CHANNEL;
            else if (addr_q[5:3] == A_SETUP0[5:3])
                setup_q[addr_q[2:0]] <= wdata[15:0] & MASK_SETUP;
            else if (addr_q[5:3] == A_FILTER0[5:3])
                filt_q[addr_q[2:0]] <= wdata[15:0] & MASK_FILTER;
            else if (addr_q[5:3] == A_OFFSET_0[5:3])
                offs_q[addr_q[2:0]] <= wdata;
            else if (addr_q[5:3] == A_GAIN_0[5:3])
                gain_q[addr_q[2:0]] <= wdata;
        end
    end

    // ****************************************
    // channel sequencer
    // ****************************************
    logic [3:0] seq_q;
    logic [3:0] nxt;

    always_comb
    begin
        nxt = seq_q;
        for (int k = 15; k >= 1; k--)
            if (chan_q[4'(seq_q + 4'(k))][CH_ENABLE_BIT])
                nxt = 4'(seq_q + 4'(k));
    end

    always_ff @(posedge core_clk_in)
    begin
        if (!nrst_in || wipe)
            seq_q <= 4'h0;
        else if (conv_tick_in)
            seq_q <= nxt;
    end

    always_ff @(posedge core_clk_in)
    begin
        if (!nrst_in)
        begin
            active_channel_out <= 4'h0;
            active_setup_out   <= 3'h0;
            bipolar_out        <= 1'b0;
            ref_select_out     <= 2'h0;
        end
        else
        begin
            active_channel_out <= seq_q;
            active_setup_out   <= chan_q[seq_q][CH_SETUP_LSB +: 3];
            bipolar_out        <= setup_q[chan_q[seq_q][CH_SETUP_LSB +: 3]][SU_POLARITY];
            ref_select_out     <= setup_q[chan_q[seq_q][CH_SETUP_LSB +: 3]][SU_REF_SEL_LSB +: 2];
        end
    end
endmodule // asr_dev
`default_nettype wire

// File: asr_pkg.sv
// constants shared by both ends of the serial register-access link
// assumes a 200 MHz core clock on both ends
`default_nettype none
package asr_pkg;
    // ****************************************
    // timing
    // ****************************************
    localparam int unsigned CLK_PERIOD_NS  = 5;
    localparam int unsigned SCLK_PERIOD_NS = 160;
    localparam int unsigned SCLK_HALF_CYC  = SCLK_PERIOD_NS / (2 * CLK_PERIOD_NS);
    localparam logic [6:0]  RESYNC_ONES    = 7'h40;
    // ****************************************
    // register addresses
    // ****************************************
    localparam logic [5:0] A_ADC_MODE  = 6'h01;
    localparam logic [5:0] A_IF_MODE   = 6'h02;
    localparam logic [5:0] A_IDENTITY  = 6'h07;
    localparam logic [5:0] A_CHANNEL0  = 6'h10;
    localparam logic [5:0] A_SETUP0    = 6'h20;
    localparam logic [5:0] A_FILTER0   = 6'h28;
    localparam logic [5:0] A_OFFSET_0  = 6'h30;
    localparam logic [5:0] A_GAIN_0    = 6'h38;
    // ****************************************
    // reset values and masks
    // ****************************************
    localparam logic [15:0] RST_ADC_MODE = 16'h2000;
    localparam logic [15:0] RST_IF_MODE  = 16'h0000;
    localparam logic [15:0] RST_CHANNEL0 = 16'h8001;
    localparam logic [15:0] RST_CHANNELN = 16'h0001;
    localparam logic [15:0] RST_SETUP    = 16'h1000;
    localparam logic [15:0] RST_FILTER   = 16'h0000;
    localparam logic [23:0] RST_OFFSET   = 24'h800000;
    localparam logic [15:0] MASK_CHANNEL = 16'hF3FF;
    localparam logic [15:0] MASK_SETUP   = 16'h1FB0;
    localparam logic [15:0] MASK_FILTER  = 16'h8F7F;
    // ****************************************
    // field positions
    // ****************************************
    localparam int unsigned CMD_WEN_BIT    = 7;
    localparam int unsigned CMD_READ_BIT   = 6;
    localparam int unsigned CH_ENABLE_BIT  = 15;
    localparam int unsigned CH_SETUP_LSB   = 12;
    localparam int unsigned CH_POS_LSB     = 5;
    localparam int unsigned CH_NEG_LSB     = 0;
    localparam int unsigned SU_POLARITY    = 12;
    localparam int unsigned SU_REF_BUF_LSB = 10;
    localparam int unsigned SU_IN_BUF_LSB  = 8;
    localparam int unsigned SU_REF_SEL_LSB = 4;
    // ****************************************
    // host controller apb map
    // ****************************************
    localparam logic [7:0] H_COMMAND  = 8'h00;
    localparam logic [7:0] H_WDATA    = 8'h04;
    localparam logic [7:0] H_RDATA    = 8'h08;
    localparam logic [7:0] H_STATUS   = 8'h0C;
    localparam logic [7:0] H_CONTROL  = 8'h10;
    localparam int unsigned H_RESYNC_BIT = 8;

    // data phase length in bits for a register address
    function automatic logic [4:0] asr_len(input logic [5:0] a);
        if (a >= A_OFFSET_0)
            return 5'h18;
        else if (a >= A_CHANNEL0 || a == A_ADC_MODE || a == A_IF_MODE || a == A_IDENTITY)
            return 5'h10;
        else
            return 5'h08;
    endfunction
endpackage
`default_nettype wire

// File: asr_if.sv
// serial link between host controller and converter register interface
// assumes the bench resolves the data-out wire from dout_oe
`timescale 1ns/100ps
`default_nettype none
interface asr_if;
    logic sclk;
    logic cs_n;
    logic din;
    logic dout;
    logic dout_oe;
    modport dev  (input sclk, input cs_n, input din, output dout, output dout_oe);
    modport host (output sclk, output cs_n, output din, input dout, input dout_oe);
endinterface
`default_nettype wire

// File: asr_host.sv
// host end: apb-programmed serial master that drives the converter link
// assumes apb on core_clk_in; dout from the pin is asynchronous
`timescale 1ns/100ps
`default_nettype none
module asr_host
    import asr_pkg::*;
(
    input  wire logic        core_clk_in,
    input  wire logic        nrst_in,
    asr_if.host              link,
    input  wire logic        psel_in,
    input  wire logic        penable_in,
    input  wire logic        pwrite_in,
    input  wire logic [7:0]  paddr_in,
    input  wire logic [31:0] pwdata_in,
    output logic [31:0]      prdata_out,
    output logic             pready_out,
    output logic             pslverr_out
);
    typedef enum logic [3:0] {
        HS_IDLE = 4'b0001, HS_LEAD = 4'b0010, HS_LOW = 4'b0100, HS_HIGH = 4'b1000
    } asr_hst_e;

    // ****************************************
    // apb slave, no wait states
    // ****************************************
    logic        busy;
    logic        use_cs_q;
    logic [23:0] wdata_q;
    logic [23:0] rdata_q;
    logic        start;
    logic        acc;

    assign acc   = psel_in & penable_in & pready_out;
    assign start = acc & pwrite_in & (paddr_in == H_COMMAND) & ~busy;

    always_ff @(posedge core_clk_in)
    begin
        if (!nrst_in)
        begin
            pready_out  <= 1'b0;
            pslverr_out <= 1'b0;
            prdata_out  <= 32'h00000000;
        end
        else
        begin
            pready_out  <= psel_in & ~penable_in;
            pslverr_out <= psel_in & ~penable_in & ~(paddr_in == H_COMMAND
                || paddr_in == H_WDATA || paddr_in == H_RDATA
                || paddr_in == H_STATUS || paddr_in == H_CONTROL);
            if (psel_in && !penable_in)
            begin
                unique case (paddr_in)
                    H_WDATA:   prdata_out <= {8'h00, wdata_q};
                    H_RDATA:   prdata_out <= {8'h00, rdata_q};
                    H_STATUS:  prdata_out <= {31'h00000000, busy};
                    H_CONTROL: prdata_out <= {31'h00000000, use_cs_q};
                    default:   prdata_out <= 32'h00000000;
                endcase
            end
        end
    end

    always_ff @(posedge core_clk_in)
    begin
        if (!nrst_in)
        begin
            wdata_q  <= 24'h000000;
            use_cs_q <= 1'b1;
        end
        else if (acc && pwrite_in && paddr_in == H_WDATA)
            wdata_q <= pwdata_in[23:0];
        else if (acc && pwrite_in && paddr_in == H_CONTROL)
            use_cs_q <= pwdata_in[0];
    end

    // ****************************************
    // serial master
    // ****************************************
    asr_hst_e    st_q;
    logic [4:0]  half_q;
    logic [6:0]  bits_q;
    logic [31:0] tx_q;
    logic [31:0] rx_q;
    logic [4:0]  len_q;
    logic        ones_q;
    logic [1:0]  dout_s_q;
    logic        half_done;
    logic [4:0]  len;

    assign busy      = (st_q != HS_IDLE);
    assign half_done = (half_q == 5'(SCLK_HALF_CYC - 1));
    assign len       = asr_len(pwdata_in[5:0]);

    always_ff @(posedge core_clk_in)
    begin
        if (!nrst_in)
            dout_s_q <= 2'h3;
        else
            dout_s_q <= {dout_s_q[0], link.dout};
    end

    always_ff @(posedge core_clk_in)
    begin
        if (!nrst_in)
        begin
            st_q      <= HS_IDLE;
            half_q    <= 5'h00;
            bits_q    <= 7'h00;
            tx_q      <= 32'h00000000;
            rx_q      <= 32'h00000000;
            len_q     <= 5'h08;
            ones_q    <= 1'b0;
            rdata_q   <= 24'h000000;
            link.sclk <= 1'b1;
            link.cs_n <= 1'b1;
            link.din  <= 1'b1;
        end
        else
        begin
            half_q <= (st_q == HS_IDLE || half_done) ? 5'h00 : half_q + 5'h01;
            unique case (st_q)
                HS_IDLE:
                    if (start)
                    begin
                        st_q      <= HS_LEAD;
                        ones_q    <= pwdata_in[H_RESYNC_BIT];
                        bits_q    <= pwdata_in[H_RESYNC_BIT] ? RESYNC_ONES
                                                              : 7'h08 + {2'h0, len};
                        len_q     <= len;
                        // command then data, both msb first
                        tx_q      <= {pwdata_in[7:0], wdata_q << (6'h18 - {1'b0, len})};
                        link.cs_n <= 1'b0;
                    end
                HS_LEAD:
                    if (half_done)
                        st_q <= HS_LOW;
                HS_LOW:
                begin
                    if (half_q == 5'h00)
                    begin
                        link.sclk <= 1'b0;
                        link.din  <= ones_q | tx_q[31];
                        tx_q      <= {tx_q[30:0], 1'b0};
                    end
                    if (half_done)
                    begin
                        st_q      <= HS_HIGH;
                        link.sclk <= 1'b1;
                        rx_q      <= {rx_q[30:0], dout_s_q[1]};
                        bits_q    <= bits_q - 7'h01;
                    end
                end
                HS_HIGH:
                    if (half_done)
                    begin
                        if (bits_q == 7'h00)
                        begin
                            st_q      <= HS_IDLE;
                            // without chip select the line stays low until a frame ends with it enabled
                            link.cs_n <= use_cs_q;
                            if (use_cs_q)
                                link.din <= 1'b1;
                            if (!ones_q)
                                rdata_q <= rx_q[23:0] & ~(24'hFFFFFF << len_q);
                        end
                        else
                            st_q <= HS_LOW;
                    end
            endcase
        end
    end
endmodule // asr_host
`default_nettype wire

// File: asr_link_properties.sv
// checker for the serial link between host and converter ends
// assumes it is instantiated beside the link interface, no bind
`timescale 1ns/100ps
`default_nettype none
module asr_link_properties
(
    input wire logic core_clk_in,
    input wire logic nrst_in,
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic din,
    input wire logic dout,
    input wire logic dout_oe
);
    logic       sclk_q;
    logic [6:0] rise_q;
    logic [7:0] cmd_q;
    logic [6:0] want;
    // ********
    // helper: rises per frame and the command byte they carry
    // ********
    always_ff @(posedge core_clk_in)
        sclk_q <= sclk;
    always_ff @(posedge core_clk_in)
    begin
        if (!nrst_in || cs_n)
            rise_q <= 7'h00;
        else if (sclk && !sclk_q && rise_q > 7'h07 && rise_q == want - 7'h01)
            rise_q <= 7'h00; // chip select may stay low across frames
        else if (sclk && !sclk_q)
            rise_q <= rise_q + 7'h01;
    end
    always_ff @(posedge core_clk_in)
    begin
        if (sclk && !sclk_q && !cs_n && rise_q < 7'h08)
            cmd_q <= {cmd_q[6:0], din};
    end
    // frame length kept independent of the design's own length function
    always_comb
    begin
        if (cmd_q == 8'hFF)
            want = 7'h40;
        else if (cmd_q[5:0] >= 6'h30)
            want = 7'h20;
        else if (cmd_q[5:0] >= 6'h10 || cmd_q[5:0] == 6'h01 || cmd_q[5:0] == 6'h02
                 || cmd_q[5:0] == 6'h07)
            want = 7'h18;
        else
            want = 7'h10;
    end
    // ********
    // properties
    // ********
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!nrst_in);
    sequence s_fall;
        $fell(sclk);
    endsequence
    sequence s_select;
        $fell(cs_n);
    endsequence
    a_idle_sclk_high: assert property (cs_n |-> sclk)
        else $error("serial clock low while deselected");
    a_din_on_fall: assert property ((!cs_n && $changed(din)) |-> $fell(sclk))
        else $error("data-in moved away from a falling clock edge");
    a_half_period: assert property (s_fall |-> !sclk [*8] ##9 sclk)
        else $error("serial clock low phase has the wrong length");
    a_first_edge: assert property (s_select |-> sclk [*8] ##[1:16] $fell(sclk))
        else $error("first drive edge misplaced after select");
    a_dout_steady: assert property (($rose(sclk) && dout_oe) |-> $stable(dout) [*4])
        else $error("data-out changed near a sample edge");
    a_frame_length: assert property ($rose(cs_n) |-> rise_q == 7'h00)
        else $error("frame bit count does not match its command");
    a_oe_follows_cs: assert property (s_select |-> ##[1:6] dout_oe)
        else $error("device did not take the line after select");
    a_oe_release: assert property (cs_n [*6] |-> !dout_oe)
        else $error("device still drives data-out while deselected");
    a_idle_dout_one: assert property (!dout_oe |-> dout)
        else $error("idle data-out not high");
endmodule // asr_link_properties
`default_nettype wire

// File: asr_tb.sv
// self-checking bench: host end programmed over apb talks to the converter end
// assumes asr_pkg, asr_if, asr_dev, asr_host and the link checker are compiled first
`timescale 1ns/100ps
`default_nettype none
module testbench
    import asr_pkg::*;
;
    localparam logic [15:0] TB_ID   = 16'h6B9E;  // arbitrary identity value
    localparam logic [23:0] TB_GAIN = 24'h5ABCD0; // arbitrary factory value
    logic        clk, nrst, psel, penable, pwrite, pready, pslverr, tick, bip, e;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, q;
    logic [3:0]  chan;
    logic [2:0]  setup;
    logic [1:0]  rsel;
    int          n_errors = 0;
    int          check_count = 0;
    logic [5:0]  rst_addr [8] = '{A_ADC_MODE, A_IF_MODE, A_CHANNEL0, 6'h11, A_SETUP0,
                                  A_FILTER0, A_OFFSET_0, A_GAIN_0};
    logic [23:0] rv [8] = '{{8'h00, RST_ADC_MODE}, {8'h00, RST_IF_MODE}, {8'h00, RST_CHANNEL0},
                            {8'h00, RST_CHANNELN}, {8'h00, RST_SETUP}, {8'h00, RST_FILTER},
                            RST_OFFSET, TB_GAIN};
    logic [5:0]  wa [5] = '{A_OFFSET_0, 6'h11, A_SETUP0, A_FILTER0, 6'h15};
    logic [23:0] wd [5] = '{24'hA55A3C, 24'h00BCA3, 24'h001FFF, 24'h00FFFF, 24'h0080A4};
    logic [23:0] we [5] = '{24'hA55A3C, 24'h00B0A3, 24'h001FB0, 24'h008F7F, 24'h0080A4};
    logic [23:0] sq [3] = '{{14'h0, 4'h1, 3'h3, 2'h0, 1'b1}, {14'h0, 4'h5, 3'h0, 2'h3, 1'b1},
                            {14'h0, 4'h0, 3'h0, 2'h3, 1'b1}};
    asr_if link ();
    asr_dev #(.ID_CODE(TB_ID), .GAIN_RESET(TB_GAIN)) asr_dev_i (.core_clk_in(clk),
        .nrst_in(nrst), .link(link), .conv_tick_in(tick), .active_channel_out(chan),
        .active_setup_out(setup), .bipolar_out(bip), .ref_select_out(rsel));
    asr_host asr_host_i (.core_clk_in(clk), .nrst_in(nrst), .link(link), .psel_in(psel),
        .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
        .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr));
    asr_link_properties asr_link_properties_i (.core_clk_in(clk), .nrst_in(nrst),
        .sclk(link.sclk), .cs_n(link.cs_n), .din(link.din), .dout(link.dout),
        .dout_oe(link.dout_oe));
    // ********
    // access tasks
    // ********
    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        check_count++;
        if (got !== exp)
        begin
            n_errors++;
            $display("ERROR %0t: read %h, expected %h", $time, got, exp);
        end
    endtask
    // request held until the edge that samples pready high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic xfer(input logic [8:0] c);
        apb(1'b1, H_COMMAND, {23'h0, c});
        do apb(1'b0, H_STATUS, 32'h0); while (q[0] !== 1'b0);
    endtask
    task automatic dwr(input logic [5:0] a, input logic [23:0] d);
        apb(1'b1, H_WDATA, {8'h00, d});
        xfer({3'b000, a});
    endtask
    task automatic rd(input logic [5:0] a);
        xfer({3'b001, a});
        apb(1'b0, H_RDATA, 32'h0);
    endtask
    task automatic close_out();
        $display("checks %0d, errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // ********
    // clock, watchdog, tests
    // ********
    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    // more than three times the expected run length
    initial
    begin
        #400000;
        n_errors++;
        $display("ERROR %0t: watchdog expired", $time);
        close_out();
    end
    initial
    begin
        nrst = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00;
        pwdata = 32'h0; tick = 1'b0;
        repeat (16) @(posedge clk);
        nrst <= 1'b1;
        rd(A_IDENTITY);
        chk({8'h00, q[15:4], 4'h0}, {8'h00, TB_ID[15:4], 4'h0});
        foreach (rst_addr[i])
        begin
            rd(rst_addr[i]);
            chk(q[23:0], rv[i]);
        end
        apb(1'b1, H_CONTROL, 32'h0);
        foreach (wa[i])
        begin
            dwr(wa[i], wd[i]);
            rd(wa[i]);
            chk(q[23:0], we[i]);
        end
        apb(1'b1, H_CONTROL, 32'h1);
        dwr(A_IDENTITY, 24'h001234);
        rd(A_IDENTITY);
        chk({8'h00, q[15:4], 4'h0}, {8'h00, TB_ID[15:4], 4'h0});
        xfer(9'h090);
        rd(A_CHANNEL0);
        chk(q[23:0], {8'h00, RST_CHANNEL0});
        chk({20'h0, chan}, 24'h0);
        foreach (sq[i])
        begin
            @(posedge clk);
            tick <= 1'b1;
            @(posedge clk);
            tick <= 1'b0;
            repeat (3) @(posedge clk);
            chk({14'h0, chan, setup, rsel, bip}, sq[i]);
        end
        xfer(9'h100);
        rd(A_OFFSET_0);
        chk(q[23:0], RST_OFFSET);
        rd(6'h11);
        chk(q[23:0], {8'h00, RST_CHANNELN});
        apb(1'b0, 8'h14, 32'h0);
        chk({23'h0, e}, 24'h000001);
        close_out();
    end
endmodule // testbench
`default_nettype wire
